// *** logic/oms_top.sv ***
`timescale 1ns/1ps
`default_nettype none
// operation mode selector with apb configuration
module oms_top
   import oms_pkg::*;
#(
   parameter int ADDR_W = 8
) (
   input  wire logic              clock_in,
   input  wire logic              reset_in,
   // apb slave
   input  wire logic              psel_in,
   input  wire logic              penable_in,
   input  wire logic              pwrite_in,
   input  wire logic [ADDR_W-1:0] paddr_in,
   input  wire logic [31:0]       pwdata_in,
   input  wire logic [3:0]        pstrb_in,
   output logic      [31:0]       prdata_out,
   output logic                   pready_out,
   output logic                   pslverr_out,
   // terminal inputs
   input  wire logic              panel_net_switch_in,
   input  wire logic              ext_net_switch_in,
   input  wire logic              panel_ext_switch_in,
   input  wire logic              panel_interlock_in,
   input  wire logic              motor_running_in,
   input  wire logic              comm_option_fitted_in,
   // results
   output oms_mode_e              mode_out,
   output logic                   output_stop_out
);

   // decode needs the full byte offset
   initial begin
      if (ADDR_W < 8) begin
         $error("oms_top: ADDR_W must be at least 8");
      end
   end

   // state of the block apart from the registered terminals
   typedef struct packed {
      oms_cfg_s    cfg;       // software settings
      oms_mode_e   mode;      // resolved mode
      logic        out_stop;  // output stop flag
      logic [31:0] rdata;     // read data for the access phase
   } oms_state_s;

   oms_state_s st_ff;   // registered state
   oms_state_s nxt_st;  // next state
   oms_term_s  t;       // registered terminals

   // terminal sampling stage
   oms_term_reg #(
      .WIDTH (OMS_TERM_W)
   ) u_term (
      .clock_in (clock_in),
      .reset_in (reset_in),
      .d_in     ({panel_net_switch_in, ext_net_switch_in, panel_ext_switch_in,
                  panel_interlock_in, motor_running_in, comm_option_fitted_in}),
      .q_out    (t)
   );

   // address decode on the low byte
   logic [7:0] addr_lo;    // byte offset
   logic       hit_cfg;    // config register
   logic       hit_stat;   // status register
   logic       addr_ok;    // mapped address
   assign addr_lo  = paddr_in[7:0];
   assign hit_cfg  = (addr_lo == OMS_OFF_CONFIG);
   assign hit_stat = (addr_lo == OMS_OFF_STATUS);
   assign addr_ok  = hit_cfg | hit_stat;

   // config as a bus word
   function automatic logic [31:0] cfg_word(input oms_cfg_s c);
      logic [31:0] w;
      w = '0;
      w[OMS_MS_LSB +: 4]  = c.mode_select_setting;
      w[OMS_SU_LSB +: 4]  = c.startup_mode_setting;
      w[OMS_NCS_LSB +: 2] = c.net_command_source_setting;
      w[OMS_ASG_PN_BIT]   = c.asg_pn;
      w[OMS_ASG_EN_BIT]   = c.asg_en;
      w[OMS_ASG_PE_BIT]   = c.asg_pe;
      return w;
   endfunction

   // target mode from settings and terminals, priority by order of tests
   function automatic oms_mode_e resolve(input oms_cfg_s c, input oms_term_s s,
                                         input oms_mode_e cur);
      logic [3:0] ms;
      logic [3:0] su;
      logic       net_ok10;
      logic       net_ok0;
      oms_mode_e  ext_side;
      ms       = c.mode_select_setting;
      su       = c.startup_mode_setting;
      // network fallback when the option is missing
      net_ok10 = !(c.net_command_source_setting == OMS_NCS_SRC0 && !s.option);
      net_ok0  = !(c.net_command_source_setting == OMS_NCS_SRC1 && !s.option);
      resolve  = cur;
      // external side of the external/network switch
      if (c.asg_pn) begin
         ext_side = s.pn ? OMS_PANEL : OMS_NET;
      end else if (c.asg_pe && !s.pe) begin
         ext_side = OMS_PANEL;
      end else begin
         ext_side = OMS_EXT;
      end
      if (ms == OMS_MS_PANEL) begin
         resolve = OMS_PANEL;
      end else if (ms == OMS_MS_COMB_A || ms == OMS_MS_COMB_B) begin
         resolve = OMS_COMBINED;
      end else if (ms == OMS_MS_INTERLK && !s.interlock) begin
         resolve = OMS_EXT;
      end else if (ms != OMS_MS_SWITCH && ms != OMS_MS_EXT_NET && ms != OMS_MS_RUN_SW
                   && ms != OMS_MS_INTERLK) begin
         resolve = cur;  // unused settings leave the mode alone
      end else if (su == OMS_SU_PANEL_NET) begin
         // panel/network switching
         if (ms == OMS_MS_EXT_NET) begin
            resolve = OMS_NET;
         end else if (c.asg_en && s.en) begin
            resolve = net_ok10 ? OMS_NET : OMS_PANEL;
         end else if (c.asg_pn) begin
            if (s.pn) begin
               resolve = OMS_PANEL;
            end else if (net_ok10) begin
               resolve = OMS_NET;
            end else begin
               resolve = (c.asg_pe && s.pe) ? OMS_EXT : OMS_PANEL;
            end
         end else if (c.asg_pe) begin
            resolve = s.pe ? OMS_EXT : OMS_PANEL;
         end
      end else begin
         // external/network switching
         if (c.asg_en && s.en) begin
            if (net_ok0) begin
               resolve = OMS_NET;
            end else begin
               resolve = (ms == OMS_MS_EXT_NET) ? OMS_EXT : OMS_PANEL;
            end
         end else if (ms == OMS_MS_EXT_NET) begin
            resolve = OMS_EXT;
         end else if (c.asg_en || c.asg_pn || c.asg_pe) begin
            resolve = ext_side;
         end
         if (ms == OMS_MS_EXT_NET && resolve == OMS_PANEL) begin
            resolve = OMS_EXT;
         end
      end
   endfunction

   // settings that fix the mode take effect at once
   function automatic logic forced(input oms_cfg_s c, input oms_term_s s);
      logic [3:0] ms;
      ms     = c.mode_select_setting;
      forced = (ms == OMS_MS_PANEL) || (ms == OMS_MS_COMB_A) || (ms == OMS_MS_COMB_B)
               || (ms == OMS_MS_INTERLK && !s.interlock)
               || (ms == OMS_MS_EXT_NET && c.startup_mode_setting == OMS_SU_PANEL_NET);
   endfunction

   oms_mode_e target;     // resolved target mode
   logic      may_move;   // switching allowed this cycle
   logic      wr_strobe;  // apb write access phase
   logic      rd_setup;   // apb setup of a read
   assign target    = resolve(st_ff.cfg, t, st_ff.mode);
   // a stop is needed unless setting 6 allows running changes or the setting fixes the mode
   assign may_move  = !t.running || (st_ff.cfg.mode_select_setting == OMS_MS_RUN_SW)
                      || forced(st_ff.cfg, t);
   assign wr_strobe = psel_in && penable_in && pwrite_in && hit_cfg;
   assign rd_setup  = psel_in && !penable_in && !pwrite_in;

   // next state
   always_comb begin
      nxt_st = st_ff;
      // mode update one cycle after the sampled inputs
      if (may_move) begin
         nxt_st.mode = target;
      end
      // interlocked external mode holds the output stopped
      nxt_st.out_stop = (st_ff.cfg.mode_select_setting == OMS_MS_INTERLK) && t.interlock
                        && (st_ff.mode == OMS_EXT);
      // byte-lane writes to the config word
      if (wr_strobe) begin
         if (pstrb_in[0]) begin
            nxt_st.cfg.mode_select_setting  = pwdata_in[OMS_MS_LSB +: 4];
            nxt_st.cfg.startup_mode_setting = pwdata_in[OMS_SU_LSB +: 4];
         end
         if (pstrb_in[1]) begin
            nxt_st.cfg.net_command_source_setting = pwdata_in[OMS_NCS_LSB +: 2];
         end
         if (pstrb_in[2]) begin
            nxt_st.cfg.asg_pn = pwdata_in[OMS_ASG_PN_BIT];
            nxt_st.cfg.asg_en = pwdata_in[OMS_ASG_EN_BIT];
            nxt_st.cfg.asg_pe = pwdata_in[OMS_ASG_PE_BIT];
         end
      end
      // read data captured in the setup cycle, zero for unmapped
      if (rd_setup) begin
         nxt_st.rdata = '0;
         if (hit_cfg) begin
            nxt_st.rdata = cfg_word(st_ff.cfg);
         end else if (hit_stat) begin
            nxt_st.rdata[OMS_ST_MODE_LSB +: 2] = st_ff.mode;
            nxt_st.rdata[OMS_ST_STOP_BIT]      = st_ff.out_stop;
            nxt_st.rdata[OMS_ST_RUN_BIT]       = t.running;
         end
      end
   end

   // state register
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         st_ff.cfg.mode_select_setting        <= OMS_MS_RST;
         st_ff.cfg.startup_mode_setting       <= OMS_SU_RST;
         st_ff.cfg.net_command_source_setting <= OMS_NCS_RST;
         st_ff.cfg.asg_pn                     <= 1'b0;
         st_ff.cfg.asg_en                     <= 1'b0;
         st_ff.cfg.asg_pe                     <= 1'b0;
         st_ff.mode                           <= OMS_MODE_RST;
         st_ff.out_stop                       <= 1'b0;
         st_ff.rdata                          <= 32'h0000_0000;
      end else begin
         st_ff <= nxt_st;
      end
   end

   // zero wait states; status is read-only so writes there error
   assign pready_out      = 1'b1;
   assign pslverr_out     = psel_in && penable_in && (!addr_ok || (pwrite_in && hit_stat));
   assign prdata_out      = st_ff.rdata;
   assign mode_out        = st_ff.mode;
   assign output_stop_out = st_ff.out_stop;

   // checks on the resolved mode and the output stop
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (reset_in);

   logic [3:0] ms_c;  // current mode select
   logic [3:0] su_c;  // current start-up setting
   assign ms_c = st_ff.cfg.mode_select_setting;
   assign su_c = st_ff.cfg.startup_mode_setting;

   property p_panel_fixed;
      (ms_c == OMS_MS_PANEL) |=> (mode_out == OMS_PANEL);
   endproperty
   a_panel_fixed: assert property (p_panel_fixed) else $error("select 1 not panel");

   property p_combined_fixed;
      (ms_c == OMS_MS_COMB_A || ms_c == OMS_MS_COMB_B) |=> (mode_out == OMS_COMBINED);
   endproperty
   a_combined_fixed: assert property (p_combined_fixed) else $error("select 3/4 not combined");

   property p_interlock_off;
      (ms_c == OMS_MS_INTERLK && !t.interlock) |=> (mode_out == OMS_EXT);
   endproperty
   a_interlock_off: assert property (p_interlock_off) else $error("interlock off not external");

   property p_net_fixed;
      (su_c == OMS_SU_PANEL_NET && ms_c == OMS_MS_EXT_NET) |=> (mode_out == OMS_NET);
   endproperty
   a_net_fixed: assert property (p_net_fixed) else $error("start-up 10 select 2 not network");

   property p_hold_running;
      (t.running && ms_c == OMS_MS_SWITCH) |=> $stable(mode_out);
   endproperty
   a_hold_running: assert property (p_hold_running) else $error("mode moved while running");

   property p_run_switch;
      (t.running && ms_c == OMS_MS_RUN_SW && su_c == OMS_SU_AS_SET && st_ff.cfg.asg_en
       && t.en && t.option) |=> (mode_out == OMS_NET);
   endproperty
   a_run_switch: assert property (p_run_switch) else $error("setting 6 blocked change");

   property p_out_stop;
      (ms_c == OMS_MS_INTERLK && t.interlock && mode_out == OMS_EXT) |=> output_stop_out;
   endproperty
   a_out_stop: assert property (p_out_stop) else $error("no output stop in external");

   property p_panel_net_on;
      (!t.running && su_c == OMS_SU_PANEL_NET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_pn
       && t.pn && !(st_ff.cfg.asg_en && t.en)) |=> (mode_out == OMS_PANEL);
   endproperty
   a_panel_net_on: assert property (p_panel_net_on) else $error("panel switch not panel");

   property p_never_panel;
      (!t.running && su_c != OMS_SU_PANEL_NET && ms_c == OMS_MS_EXT_NET) |=> (mode_out != OMS_PANEL);
   endproperty
   a_never_panel: assert property (p_never_panel) else $error("select 2 reached panel");

   property p_no_option;
      (!t.running && su_c == OMS_SU_AS_SET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && t.en
       && !t.option && st_ff.cfg.net_command_source_setting == OMS_NCS_SRC1)
      |=> (mode_out == OMS_PANEL);
   endproperty
   a_no_option: assert property (p_no_option) else $error("no option fallback missed");

   // external/network switching, stopped, option fitted: switch on means network
   property p_net_switch_on;
      (!t.running && su_c == OMS_SU_AS_SET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && t.en
       && t.option) |=> (mode_out == OMS_NET);
   endproperty
   a_net_switch_on: assert property (p_net_switch_on) else $error("ext/net switch on not network");

   // switch off with no other switch assigned falls back to external
   property p_net_switch_off;
      (!t.running && su_c == OMS_SU_AS_SET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && !t.en
       && !st_ff.cfg.asg_pn && !st_ff.cfg.asg_pe) |=> (mode_out == OMS_EXT);
   endproperty
   a_net_switch_off: assert property (p_net_switch_off) else $error("ext/net switch off not external");

   // external side with panel/external switch low picks panel
   property p_ext_side_panel;
      (!t.running && su_c == OMS_SU_AS_SET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && !t.en
       && !st_ff.cfg.asg_pn && st_ff.cfg.asg_pe && !t.pe) |=> (mode_out == OMS_PANEL);
   endproperty
   a_ext_side_panel: assert property (p_ext_side_panel) else $error("external side not panel");

   // an assigned panel/network switch overrules the panel/external switch
   property p_pn_decides;
      (!t.running && su_c == OMS_SU_AS_SET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && !t.en
       && st_ff.cfg.asg_pn && t.pn) |=> (mode_out == OMS_PANEL);
   endproperty
   a_pn_decides: assert property (p_pn_decides) else $error("panel/network switch ignored");

   // panel/network switching: ext/net switch on keeps network
   property p_ext_net_wins;
      (!t.running && su_c == OMS_SU_PANEL_NET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_en && t.en
       && !t.pn && t.option) |=> (mode_out == OMS_NET);
   endproperty
   a_ext_net_wins: assert property (p_ext_net_wins) else $error("ext/net switch lost network");

   // network refused, panel/external switch low or unassigned gives panel
   property p_pn_fallback;
      (!t.running && su_c == OMS_SU_PANEL_NET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_pn && !t.pn
       && !(st_ff.cfg.asg_en && t.en) && !t.option && st_ff.cfg.net_command_source_setting == OMS_NCS_SRC0
       && !(st_ff.cfg.asg_pe && t.pe)) |=> (mode_out == OMS_PANEL);
   endproperty
   a_pn_fallback: assert property (p_pn_fallback) else $error("source 0 fallback not panel");

   // network refused, panel/external switch high gives external
   property p_pe_fallback;
      (!t.running && su_c == OMS_SU_PANEL_NET && ms_c == OMS_MS_SWITCH && st_ff.cfg.asg_pn && !t.pn
       && !(st_ff.cfg.asg_en && t.en) && !t.option && st_ff.cfg.net_command_source_setting == OMS_NCS_SRC0
       && st_ff.cfg.asg_pe && t.pe) |=> (mode_out == OMS_EXT);
   endproperty
   a_pe_fallback: assert property (p_pe_fallback) else $error("fallback with switch high not external");

   // interlock on lets the ext/net switch reach network
   property p_il_net;
      (!t.running && ms_c == OMS_MS_INTERLK && t.interlock && su_c != OMS_SU_PANEL_NET
       && st_ff.cfg.asg_en && t.en && t.option) |=> (mode_out == OMS_NET);
   endproperty
   a_il_net: assert property (p_il_net) else $error("interlock on blocked network");

   // a blocked cycle must leave the registered mode untouched
   property p_mode_lag;
      (!may_move) |=> $stable(mode_out);
   endproperty
   a_mode_lag: assert property (p_mode_lag) else $error("mode moved while blocked");

endmodule
`default_nettype wire

// *** logic/oms_pkg.sv ***
package oms_pkg;

   // resolved command mode
   typedef enum logic [1:0] {
      OMS_EXT,
      OMS_PANEL,
      OMS_NET,
      OMS_COMBINED
   } oms_mode_e;

   // register byte offsets
   localparam logic [7:0] OMS_OFF_CONFIG = 8'h00;
   localparam logic [7:0] OMS_OFF_STATUS = 8'h04;

   // config field positions
   localparam int OMS_MS_LSB     = 0;
   localparam int OMS_SU_LSB     = 4;
   localparam int OMS_NCS_LSB    = 8;
   localparam int OMS_ASG_PN_BIT = 16;
   localparam int OMS_ASG_EN_BIT = 17;
   localparam int OMS_ASG_PE_BIT = 18;

   // status field positions
   localparam int OMS_ST_MODE_LSB = 0;
   localparam int OMS_ST_STOP_BIT = 2;
   localparam int OMS_ST_RUN_BIT  = 3;

   // mode select setting values
   localparam logic [3:0] OMS_MS_SWITCH   = 4'h0;
   localparam logic [3:0] OMS_MS_PANEL    = 4'h1;
   localparam logic [3:0] OMS_MS_EXT_NET  = 4'h2;
   localparam logic [3:0] OMS_MS_COMB_A   = 4'h3;
   localparam logic [3:0] OMS_MS_COMB_B   = 4'h4;
   localparam logic [3:0] OMS_MS_RUN_SW   = 4'h6;
   localparam logic [3:0] OMS_MS_INTERLK  = 4'h7;

   // start-up mode setting values
   localparam logic [3:0] OMS_SU_AS_SET    = 4'h0;
   localparam logic [3:0] OMS_SU_NET       = 4'h1;
   localparam logic [3:0] OMS_SU_PANEL_NET = 4'hA;

   // network command source values
   localparam logic [1:0] OMS_NCS_SRC0 = 2'h0;
   localparam logic [1:0] OMS_NCS_SRC1 = 2'h1;

   // reset values
   localparam logic [3:0] OMS_MS_RST   = 4'h0;
   localparam logic [3:0] OMS_SU_RST   = 4'h0;
   localparam logic [1:0] OMS_NCS_RST  = 2'h0;
   localparam oms_mode_e  OMS_MODE_RST = OMS_EXT;

   // configuration settings
   typedef struct packed {
      logic [3:0] mode_select_setting;
      logic [3:0] startup_mode_setting;
      logic [1:0] net_command_source_setting;
      logic       asg_pn;  // code 65 assigned to a terminal
      logic       asg_en;  // code 66 assigned to a terminal
      logic       asg_pe;  // panel/external switch assigned
   } oms_cfg_s;

   // terminal inputs
   typedef struct packed {
      logic pn;        // panel/network switch
      logic en;        // external/network switch
      logic pe;        // panel/external switch
      logic interlock; // panel interlock
      logic running;   // motor running or start on
      logic option;    // communication option fitted
   } oms_term_s;

   localparam int OMS_TERM_W = $bits(oms_term_s);

endpackage

// *** logic/oms_term_reg.sv ***
`timescale 1ns/1ps
`default_nettype none
// register stage for the terminal inputs
module oms_term_reg #(
   parameter int WIDTH = 6
) (
   input  wire logic             clock_in,
   input  wire logic             reset_in,
   input  wire logic [WIDTH-1:0] d_in,
   output logic      [WIDTH-1:0] q_out
);
   // width must be usable
   initial begin
      if (WIDTH < 1) begin
         $error("oms_term_reg: WIDTH must be at least 1");
      end
   end

   logic [WIDTH-1:0] q_ff;  // sampled copy

   // one flop per input, cleared on reset
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         q_ff <= '0;
      end else begin
         q_ff <= d_in;
      end
   end

   assign q_out = q_ff;
endmodule
`default_nettype wire

// *** test/oms_term_drv.sv ***
`timescale 1ns/1ps
`default_nettype none
// stands in for the external controller that drives the terminal pins
module oms_term_drv
   import oms_pkg::*;
(
   input  wire logic      clock_in,
   input  wire logic      reset_in,
   input  wire oms_term_s cmd_in,        // wanted pin levels
   output logic           panel_net_out, // panel/network switch
   output logic           ext_net_out,   // external/network switch
   output logic           panel_ext_out, // panel/external switch
   output logic           interlock_out, // panel interlock
   output logic           running_out,   // motor running
   output logic           option_out     // communication option fitted
);
   // pins move only just after a rising edge, like real relay logic behind a sampler
   always_ff @(posedge clock_in or posedge reset_in) begin
      if (reset_in) begin
         {panel_net_out, ext_net_out, panel_ext_out} <= 3'h0;
         {interlock_out, running_out, option_out}    <= 3'h0;
      end else begin
         {panel_net_out, ext_net_out, panel_ext_out} <= {cmd_in.pn, cmd_in.en, cmd_in.pe};
         {interlock_out, running_out, option_out}    <= {cmd_in.interlock, cmd_in.running, cmd_in.option};
      end
   end
endmodule
`default_nettype wire

// *** test/operation_mode_selector_tb.sv ***
`timescale 1ns/1ps
`default_nettype none
// self-checking bench for the mode selector
module operation_mode_selector_tb
   import oms_pkg::*;
;
   logic        clock_in;
   logic        reset_in;
   logic        psel, penable, pwrite;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata_out;
   logic        pready_out, pslverr_out;
   logic        pn_w, en_w, pe_w, il_w, run_w, opt_w; // driver to design pins
   oms_mode_e   mode_out;
   logic        output_stop_out;
   oms_term_s   term;        // pin levels the bench wants
   int          err_count;
   int          comparisons;
   int          cycles = 0;

   oms_top dut (.clock_in(clock_in), .reset_in(reset_in), .psel_in(psel), .penable_in(penable),
      .pwrite_in(pwrite), .paddr_in(paddr), .pwdata_in(pwdata), .pstrb_in(4'hF),
      .prdata_out(prdata_out), .pready_out(pready_out), .pslverr_out(pslverr_out),
      .panel_net_switch_in(pn_w), .ext_net_switch_in(en_w), .panel_ext_switch_in(pe_w),
      .panel_interlock_in(il_w), .motor_running_in(run_w), .comm_option_fitted_in(opt_w),
      .mode_out(mode_out), .output_stop_out(output_stop_out));

   oms_term_drv drv (.clock_in(clock_in), .reset_in(reset_in), .cmd_in(term),
      .panel_net_out(pn_w), .ext_net_out(en_w), .panel_ext_out(pe_w),
      .interlock_out(il_w), .running_out(run_w), .option_out(opt_w));

   // free running clock, 10 ns period
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end

   // hang guard: the run needs a few hundred cycles, the ceiling leaves wide margin
   always @(posedge clock_in) begin
      cycles <= cycles + 1;
      if (cycles == 20000) begin
         err_count = err_count + 1;
         conclude();
      end
   end

   task automatic conclude();
      if (err_count == 0 && comparisons > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   // one comparison, counted
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      comparisons = comparisons + 1;
      if (g !== e) begin
         $display("BAD %s expected %h seen %h", nm, e, g);
         err_count = err_count + 1;
      end
   endtask

   // one apb transfer; waits for pready however long it takes
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      @(posedge clock_in);
      psel    <= 1'b1;
      penable <= 1'b0;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge clock_in);
      penable <= 1'b1;
      do @(posedge clock_in); while (pready_out !== 1'b1);
      rd = prdata_out;
      err = pslverr_out;
      psel    <= 1'b0;
      penable <= 1'b0;
   endtask

   // config word: asg = {panel/external, code 66, code 65}
   task automatic cfg(input logic [3:0] ms, input logic [3:0] su, input logic [1:0] ncs,
                      input logic [2:0] asg);
      logic [31:0] rd;
      logic        er;
      apb(1'b1, OMS_OFF_CONFIG, {13'h0, asg, 6'h0, ncs, su, ms}, rd, er);
   endtask

   // pins are {pn, en, pe, interlock, running, option}; mode settles within 6 cycles
   task automatic go(input logic [5:0] t, input oms_mode_e e, input string nm);
      @(posedge clock_in);
      term <= t;
      repeat (6) @(posedge clock_in);
      chk(nm, 32'(e), 32'(mode_out));
   endtask

   task automatic t_regs();
      logic [31:0] rd;
      logic        er;
      apb(1'b0, OMS_OFF_CONFIG, 32'h0, rd, er);
      chk("config reset", 32'h0, rd);
      apb(1'b0, OMS_OFF_STATUS, 32'h0, rd, er);
      chk("status reset", 32'h0, rd);
      apb(1'b1, OMS_OFF_CONFIG, 32'hFFFF_FFFF, rd, er);
      apb(1'b0, OMS_OFF_CONFIG, 32'h0, rd, er);
      chk("config fields", 32'h0007_03FF, rd);
      apb(1'b1, OMS_OFF_STATUS, 32'h0, rd, er);
      chk("status write refused", 32'h1, 32'(er));
      apb(1'b0, 8'h08, 32'h0, rd, er);
      chk("unmapped error", 32'h1, 32'(er));
      chk("unmapped data", 32'h0, rd);
   endtask

   task automatic t_extnet();
      cfg(4'h0, 4'h0, 2'h0, 3'b010);
      go(6'b010001, OMS_NET, "ext/net on");
      go(6'b000001, OMS_EXT, "ext/net off");
      cfg(4'h0, 4'h0, 2'h0, 3'b110);
      go(6'b000001, OMS_PANEL, "pe low");
      go(6'b001001, OMS_EXT, "pe high");
      cfg(4'h0, 4'h0, 2'h0, 3'b111);
      go(6'b101001, OMS_PANEL, "pn decides");
      go(6'b110001, OMS_NET, "ext/net beats pn");
      cfg(4'h0, 4'h0, 2'h1, 3'b010);
      go(6'b010000, OMS_PANEL, "no option src1");
   endtask

   task automatic t_panelnet();
      cfg(4'h0, 4'hA, 2'h0, 3'b001);
      go(6'b100001, OMS_PANEL, "pn on");
      go(6'b000001, OMS_NET, "pn off");
      cfg(4'h0, 4'hA, 2'h0, 3'b101);
      go(6'b000000, OMS_PANEL, "no option src0");
      go(6'b001000, OMS_EXT, "fallback pe high");
      cfg(4'h0, 4'hA, 2'h0, 3'b011);
      go(6'b010001, OMS_NET, "ext/net keeps net");
   endtask

   task automatic t_fixed();
      cfg(4'h1, 4'h0, 2'h0, 3'b111);
      go(6'b010001, OMS_PANEL, "select 1");
      cfg(4'h3, 4'h0, 2'h0, 3'b111);
      go(6'b110001, OMS_COMBINED, "select 3");
      cfg(4'h4, 4'h0, 2'h0, 3'b111);
      go(6'b001001, OMS_COMBINED, "select 4");
      cfg(4'h2, 4'hA, 2'h0, 3'b111);
      go(6'b100001, OMS_NET, "startup10 select2");
      cfg(4'h2, 4'h0, 2'h0, 3'b110);
      go(6'b000001, OMS_EXT, "select2 no panel");
      go(6'b010001, OMS_NET, "select2 to net");
      cfg(4'h5, 4'h0, 2'h0, 3'b110);
      go(6'b000001, OMS_NET, "select 5 holds");
   endtask

   task automatic t_running();
      cfg(4'h0, 4'h0, 2'h0, 3'b010);
      go(6'b000001, OMS_EXT, "stopped ext");
      go(6'b010011, OMS_EXT, "held while running");
      go(6'b010001, OMS_NET, "after stop");
      cfg(4'h6, 4'h0, 2'h0, 3'b010);
      go(6'b000011, OMS_EXT, "select6 running");
      go(6'b010011, OMS_NET, "select6 back");
   endtask

   task automatic t_interlock();
      logic [31:0] rd;
      logic        er;
      cfg(4'h7, 4'h1, 2'h0, 3'b010);
      go(6'b010001, OMS_EXT, "interlock off");
      chk("stop off", 32'h0, 32'(output_stop_out));
      go(6'b010101, OMS_NET, "interlock on net");
      go(6'b000101, OMS_EXT, "interlock on ext");
      chk("stop in ext", 32'h1, 32'(output_stop_out));
      apb(1'b0, OMS_OFF_STATUS, 32'h0, rd, er);
      chk("status stop", 32'h4, rd);
      go(6'b000001, OMS_EXT, "forced ext");
      chk("stop cleared", 32'h0, 32'(output_stop_out));
   endtask

   // main sequence: reset for 8 cycles, then each scenario
   initial begin
      err_count = 0;
      comparisons = 0;
      reset_in = 1'b1;
      {psel, penable, pwrite} = 3'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      term = '0;
      repeat (8) @(posedge clock_in);
      reset_in <= 1'b0;
      t_regs();
      t_extnet();
      t_panelnet();
      t_fixed();
      t_running();
      t_interlock();
      conclude();
   end
endmodule
`default_nettype wire
